// >>> ctsc_consts.svh
`ifndef CTSC_CONSTS_SVH
`define CTSC_CONSTS_SVH

// ****************************************************************
// channel configuration word layout
// ****************************************************************
`define CTSC_CFG_W          16
`define CTSC_CFG_RESET      16'h0008
`define CTSC_SEL_HI         13
`define CTSC_SEL_LO         12
`define CTSC_FAST_OFF_BIT   11
`define CTSC_SUP_RES_BIT    10
`define CTSC_RSVD0_BIT      9
`define CTSC_IMON_BIT       8
`define CTSC_CONT_BIT       7
`define CTSC_WARN_BIT       6
`define CTSC_MODE_HI        5
`define CTSC_MODE_LO        4
`define CTSC_RSVD1_BIT      3
`define CTSC_WPD_BIT        2

// ****************************************************************
// selector and mode codes
// ****************************************************************
`define CTSC_SEL_A          2'h0
`define CTSC_SEL_B          2'h1
`define CTSC_MODE_SERVO     2'h0
`define CTSC_MODE_OPEN      2'h1
`define CTSC_MODE_DIRECT    2'h2
`define CTSC_MODE_SOFT      2'h3

// ****************************************************************
// supervisor step sizes in tenths of a millivolt
// ****************************************************************
`define CTSC_STEP_W         10
`define CTSC_STEP_FINE      10'h160
`define CTSC_STEP_COARSE    10'h2C0
`define CTSC_STEP_LV_FINE   10'h010
`define CTSC_STEP_LV_COARSE 10'h020

`endif

// >>> ctsc_pkg.sv
package ctsc_pkg;
  // channel sequencing state
  typedef enum logic [1:0] {CH_OFF, CH_RISE, CH_RUN} ctsc_chan_e;
  // trim converter state
  typedef enum logic [2:0] {DAC_IDLE, DAC_SOFT, DAC_SERVO, DAC_HOLD, DAC_LIVE} ctsc_dac_e;

  // decoded configuration word
  typedef struct packed {
    logic [1:0] seqSel;
    logic       fastServoOff;
    logic       supCoarse;
    logic       imonBuffered;
    logic       servoContinuous;
    logic       servoOnWarn;
    logic [1:0] dacMode;
    logic       softDischarge;
  } ctsc_cfg_s;

  // enable pin drive
  typedef struct packed {
    logic drive;
    logic fastPulldown;
    logic weakPulldown;
  } ctsc_en_s;
endpackage

// >>> ctsc_channel.sv
`timescale 1ns/1ps
`include "ctsc_consts.svh"
// What this block does
// - two-bit field picks sequence input a (00) or b (01); others reserved
// - fast servo bit: clear keeps fast servo on, set turns it off
// - resolution bit picks 35.2 or 70.4 mV steps; low variant 1.6 or 3.2, but reset loads 35.2 in both
// - range bit picks resistor sensing (+-80 mV) or buffered monitor mode
// - continuous bit keeps servoing after arrival, only in mode 00
// - re-servo to nominal on warning limit, mode 00 without continuous only
// - after rise time, mode picks servo, open, direct or soft connect
// - direct mode after reset or reload drives the stored startup value
// - clear pull-down bit: fast discharge of enable pin whenever channel off
// - set bit: soft stop discharges weakly, fault stop still discharges fast
// - when the pin is used, channel waits for its selected sequence input
module ctsc_channel #(
  parameter int          DAC_W    = 10,
  parameter bit          LOW_VOLT = 1'b0
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        nrst,
  // configuration word access
  input  wire logic                        cfgWrEn,
  input  wire logic [`CTSC_CFG_W-1:0]      cfgWrData,
  output logic      [`CTSC_CFG_W-1:0]      cfgRdData,
  // sequence input pins
  input  wire logic                        sequence_input_a,
  input  wire logic                        sequence_input_b,
  // on/off control from the manager core
  input  wire logic                        useSeqPin,
  input  wire logic                        opOn,
  input  wire logic                        faultOff,
  input  wire logic                        riseElapsed,
  // servo and warning status
  input  wire logic                        atTarget,
  input  wire logic                        softDone,
  input  wire logic                        overWarn,
  input  wire logic                        underWarn,
  // trim values
  input  wire logic                        userReload,
  input  wire logic                        dacWrite,
  input  wire logic [DAC_W-1:0]            dacRuntime,
  input  wire logic [DAC_W-1:0]            dacStartup,
  // channel and trim outputs
  output logic                             chanOn,
  output logic                             fastServoEn,
  output logic      [`CTSC_STEP_W-1:0]     supStep,
  output logic                             imonBuffered,
  output logic                             dacConnected,
  output logic                             dacSoftConnecting,
  output logic                             servoActive,
  output logic                             servoToNominal,
  output logic                             dacWriteOk,
  output logic      [DAC_W-1:0]            dacOut,
  // converter enable pin
  output ctsc_pkg::ctsc_en_s               enPin
);
  import ctsc_pkg::*;
  // ****************************************************************
  // configuration register
  // ****************************************************************
  ctsc_cfg_s cfg_q, cfg_d;
  // reserved positions are never stored, so writes there have no effect
  always_comb begin
    cfg_d = cfg_q;
    if (cfgWrEn) begin
      cfg_d.seqSel          = cfgWrData[`CTSC_SEL_HI:`CTSC_SEL_LO];
      cfg_d.fastServoOff    = cfgWrData[`CTSC_FAST_OFF_BIT];
      cfg_d.supCoarse       = cfgWrData[`CTSC_SUP_RES_BIT];
      cfg_d.imonBuffered    = cfgWrData[`CTSC_IMON_BIT];
      cfg_d.servoContinuous = cfgWrData[`CTSC_CONT_BIT];
      cfg_d.servoOnWarn     = cfgWrData[`CTSC_WARN_BIT];
      cfg_d.dacMode         = cfgWrData[`CTSC_MODE_HI:`CTSC_MODE_LO];
      cfg_d.softDischarge   = cfgWrData[`CTSC_WPD_BIT];
    end
  end
  // readback word with fixed reserved bits
  logic [`CTSC_CFG_W-1:0] rd_d;
  always_comb begin
    rd_d                                  = '0;
    rd_d[`CTSC_SEL_HI:`CTSC_SEL_LO]       = cfg_d.seqSel;
    rd_d[`CTSC_FAST_OFF_BIT]              = cfg_d.fastServoOff;
    rd_d[`CTSC_SUP_RES_BIT]               = cfg_d.supCoarse;
    rd_d[`CTSC_RSVD0_BIT]                 = 1'b0;
    rd_d[`CTSC_IMON_BIT]                  = cfg_d.imonBuffered;
    rd_d[`CTSC_CONT_BIT]                  = cfg_d.servoContinuous;
    rd_d[`CTSC_WARN_BIT]                  = cfg_d.servoOnWarn;
    rd_d[`CTSC_MODE_HI:`CTSC_MODE_LO]     = cfg_d.dacMode;
    rd_d[`CTSC_RSVD1_BIT]                 = 1'b1;
    rd_d[`CTSC_WPD_BIT]                   = cfg_d.softDischarge;
  end
  // static decodes, all registered so outputs leave flip-flops
  logic [`CTSC_STEP_W-1:0] step_d;
  always_comb begin
    if (LOW_VOLT) begin
      step_d = cfg_d.supCoarse ? `CTSC_STEP_LV_COARSE : `CTSC_STEP_LV_FINE;
    end else begin
      step_d = cfg_d.supCoarse ? `CTSC_STEP_COARSE : `CTSC_STEP_FINE;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q        <= '0;
      cfgRdData    <= `CTSC_CFG_RESET;
      supStep      <= `CTSC_STEP_FINE;
      fastServoEn  <= 1'b1;
      imonBuffered <= 1'b0;
    end else begin
      cfg_q        <= cfg_d;
      cfgRdData    <= rd_d;
      supStep      <= step_d;
      fastServoEn  <= ~cfg_d.fastServoOff;
      imonBuffered <= cfg_d.imonBuffered;
    end
  end
  // ****************************************************************
  // sequence pin synchronisers
  // ****************************************************************
  logic [1:0] pinMeta_q, pinSync_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q <= 2'h0;
      pinSync_q <= 2'h0;
    end else begin
      pinMeta_q <= {sequence_input_b, sequence_input_a};
      pinSync_q <= pinMeta_q;
    end
  end
  // reserved selector codes never count as asserted
  logic seqAsserted;
  always_comb begin
    case (cfg_q.seqSel)
      `CTSC_SEL_A: seqAsserted = pinSync_q[0];
      `CTSC_SEL_B: seqAsserted = pinSync_q[1];
      default:     seqAsserted = 1'b0;
    endcase
  end
  // ****************************************************************
  // channel on/off sequencing
  // ****************************************************************
  ctsc_chan_e chan_q, chan_d;
  logic       faultStop_q, faultStop_d;
  logic       runReq;
  always_comb begin
    runReq      = opOn && !faultOff && (!useSeqPin || seqAsserted);
    chan_d      = chan_q;
    faultStop_d = faultStop_q;
    case (chan_q)
      CH_OFF: begin
        if (runReq) begin
          chan_d      = CH_RISE;
          faultStop_d = 1'b0;
        end
      end
      CH_RISE, CH_RUN: begin
        if (!runReq) begin
          chan_d      = CH_OFF;
          faultStop_d = faultOff; // remembers why the channel went down
        end else if (chan_q == CH_RISE && riseElapsed) begin
          chan_d = CH_RUN;
        end
      end
      default: chan_d = CH_OFF;
    endcase
  end
  // enable pin drive; uses the word being written so the pull-down kind never lags it
  ctsc_en_s en_d;
  always_comb begin
    en_d.drive        = (chan_d != CH_OFF);
    en_d.fastPulldown = !en_d.drive && (!cfg_d.softDischarge || faultStop_d);
    en_d.weakPulldown = !en_d.drive && cfg_d.softDischarge && !faultStop_d;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chan_q      <= CH_OFF;
      faultStop_q <= 1'b0;
      chanOn      <= 1'b0;
      enPin       <= '{drive: 1'b0, fastPulldown: 1'b1, weakPulldown: 1'b0};
    end else begin
      chan_q      <= chan_d;
      faultStop_q <= faultStop_d;
      chanOn      <= (chan_d != CH_OFF);
      enPin       <= en_d;
    end
  end
  // ****************************************************************
  // trim converter control
  // ****************************************************************
  ctsc_dac_e       dac_q, dac_d;
  logic            useStartup_q, useStartup_d;
  logic            nominal_q, nominal_d;
  logic            warnHit;
  logic [DAC_W-1:0] dacOut_d;
  always_comb begin
    warnHit      = overWarn || underWarn;
    dac_d        = dac_q;
    nominal_d    = nominal_q;
    // startup value holds from reset or reload until a runtime write
    useStartup_d = userReload ? 1'b1 : (dacWrite ? 1'b0 : useStartup_q);
    if (chan_q != CH_RUN) begin
      dac_d     = DAC_IDLE;
      nominal_d = 1'b0;
    end else begin
      case (dac_q)
        DAC_IDLE: begin
          case (cfg_q.dacMode)
            `CTSC_MODE_SERVO:  dac_d = DAC_SOFT;
            `CTSC_MODE_DIRECT: dac_d = DAC_LIVE;
            `CTSC_MODE_SOFT:   dac_d = DAC_SOFT;
            default:           dac_d = DAC_IDLE;
          endcase
        end
        DAC_SOFT: begin
          if (softDone) begin
            dac_d = (cfg_q.dacMode == `CTSC_MODE_SERVO) ? DAC_SERVO : DAC_LIVE;
          end
        end
        DAC_SERVO: begin
          if (atTarget && !cfg_q.servoContinuous) begin
            dac_d     = DAC_HOLD;
            nominal_d = 1'b0;
          end
        end
        DAC_HOLD: begin
          if (cfg_q.servoContinuous) begin
            dac_d = DAC_SERVO;
          end else if (cfg_q.servoOnWarn && warnHit) begin
            dac_d     = DAC_SERVO;
            nominal_d = 1'b1;
          end
        end
        DAC_LIVE: dac_d = DAC_LIVE;
        default:  dac_d = DAC_IDLE;
      endcase
      // a mode change while running restarts the connect sequence
      if (cfgWrEn && cfg_d.dacMode != cfg_q.dacMode) begin
        dac_d = DAC_IDLE;
      end
    end
    dacOut_d = useStartup_d ? dacStartup : dacRuntime;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dac_q             <= DAC_IDLE;
      useStartup_q      <= 1'b1;
      nominal_q         <= 1'b0;
      dacConnected      <= 1'b0;
      dacSoftConnecting <= 1'b0;
      servoActive       <= 1'b0;
      servoToNominal    <= 1'b0;
      dacWriteOk        <= 1'b0;
      dacOut            <= '0;
    end else begin
      dac_q             <= dac_d;
      useStartup_q      <= useStartup_d;
      nominal_q         <= nominal_d;
      dacConnected      <= dac_d inside {DAC_SERVO, DAC_HOLD, DAC_LIVE};
      dacSoftConnecting <= (dac_d == DAC_SOFT);
      servoActive       <= (dac_d == DAC_SERVO);
      servoToNominal    <= nominal_d;
      dacWriteOk        <= (dac_d == DAC_LIVE) && (cfg_q.dacMode == `CTSC_MODE_SOFT);
      dacOut            <= dacOut_d;
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence seqStopByFault;
    chanOn ##1 !chanOn && faultStop_q;
  endsequence
  rsvd_readback_a: assert property (!cfgRdData[`CTSC_RSVD0_BIT] && cfgRdData[`CTSC_RSVD1_BIT])
    else $error("reserved bits read wrong");
  sel_gate_a: assert property ($rose(chanOn) && $past(useSeqPin) |-> $past(seqAsserted))
    else $error("channel started without its sequence input");
  fast_servo_a: assert property (cfgWrEn |=> fastServoEn == !$past(cfgWrData[`CTSC_FAST_OFF_BIT]))
    else $error("fast servo enable does not follow config");
  step_size_a: assert property (!LOW_VOLT && cfg_q.supCoarse |-> supStep == `CTSC_STEP_COARSE)
    else $error("supervisor step wrong");
  imon_mode_a: assert property (imonBuffered == cfg_q.imonBuffered)
    else $error("current sense range mismatch");
  cont_servo_a: assert property (servoActive && cfg_q.servoContinuous && chanOn && !cfgWrEn
                                 |=> servoActive || !chanOn)
    else $error("continuous servo stopped");
  open_mode_a: assert property (cfg_q.dacMode == `CTSC_MODE_OPEN && !cfgWrEn [*2]
                                |-> !dacConnected)
    else $error("dac connected in open mode");
  startup_val_a: assert property ($past(userReload) |-> dacOut == $past(dacStartup))
    else $error("startup dac value not used");
  fault_fast_a: assert property (seqStopByFault |-> enPin.fastPulldown && !enPin.weakPulldown)
    else $error("fault stop not using fast pull-down");
  off_fast_a: assert property (!chanOn && !cfg_q.softDischarge |-> enPin.fastPulldown)
    else $error("off channel without fast pull-down");
  warn_reservo_a: assert property (dac_q == DAC_HOLD && chan_d == CH_RUN && !cfgWrEn
                                   && cfg_q.servoOnWarn && !cfg_q.servoContinuous && warnHit
                                   |=> servoActive && servoToNominal)
    else $error("no re-servo on warning");
endmodule

// >>> ctsc_conv_model.sv
`timescale 1ns/1ps
// ****************************************************************
// converter model: answers soft connect and servo arrival
// ****************************************************************
module ctsc_conv_model (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // manager side
  input  wire logic               slow,
  input  wire logic               dacSoftConnecting,
  input  wire logic               servoActive,
  input  wire ctsc_pkg::ctsc_en_s enPin,
  // status back to the manager
  output logic                    softDone,
  output logic                    atTarget
);
  import ctsc_pkg::*;
  logic [3:0] waitQ;
  logic [3:0] lim;
  logic       busy;
  // a disabled converter never settles, so nothing is reported then
  assign busy = (dacSoftConnecting | servoActive) & enPin.drive;
  assign lim = slow ? 4'h6 : 4'h1;
  assign softDone = dacSoftConnecting & busy & (waitQ >= lim);
  assign atTarget = servoActive & busy & (waitQ >= lim);
  // settling counter, restarts after each report
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) waitQ <= 4'h0;
    else if (!busy || softDone || atTarget) waitQ <= 4'h0;
    else if (waitQ != 4'hF) waitQ <= waitQ + 4'h1;
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`include "ctsc_consts.svh"
module tb_top;
  import ctsc_pkg::*;
  logic ref_clk = 1'b0, nrst = 1'b0, cfgWrEn = 1'b0, seqA = 1'b0, seqB = 1'b0;
  logic useSeqPin = 1'b0, opOn = 1'b0, faultOff = 1'b0, riseElapsed = 1'b0;
  logic overWarn = 1'b0, underWarn = 1'b0, userReload = 1'b0, dacWrite = 1'b0;
  logic slow = 1'b0, softDone, atTarget, chanOn, fastServoEn, imonBuffered;
  logic dacConnected, dacSoftConnecting, servoActive, servoToNominal, dacWriteOk;
  logic [15:0] cfgWrData = 16'h0000, cfgRdData, w;
  logic [9:0]  dacRuntime = 10'h0, dacStartup = 10'h0, dacOut, supStep;
  ctsc_en_s    enPin;
  logic [6:0]  obs;
  int          errors = 0, tests_run = 0;
  // watched flags, indexed by wait_for
  assign obs = {enPin.weakPulldown, enPin.fastPulldown, servoToNominal, servoActive,
                dacWriteOk, dacConnected, chanOn};
  // free running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  ctsc_channel uut (.ref_clk(ref_clk), .nrst(nrst), .cfgWrEn(cfgWrEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .sequence_input_a(seqA),
    .sequence_input_b(seqB), .useSeqPin(useSeqPin), .opOn(opOn), .faultOff(faultOff),
    .riseElapsed(riseElapsed), .atTarget(atTarget), .softDone(softDone),
    .overWarn(overWarn), .underWarn(underWarn), .userReload(userReload),
    .dacWrite(dacWrite), .dacRuntime(dacRuntime), .dacStartup(dacStartup),
    .chanOn(chanOn), .fastServoEn(fastServoEn), .supStep(supStep),
    .imonBuffered(imonBuffered), .dacConnected(dacConnected),
    .dacSoftConnecting(dacSoftConnecting), .servoActive(servoActive),
    .servoToNominal(servoToNominal), .dacWriteOk(dacWriteOk), .dacOut(dacOut),
    .enPin(enPin));
  ctsc_conv_model conv (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
    .dacSoftConnecting(dacSoftConnecting), .servoActive(servoActive), .enPin(enPin),
    .softDone(softDone), .atTarget(atTarget));
  // ****************************************************************
  // checking helpers
  // ****************************************************************
  function automatic logic [15:0] exp_rd(input logic [15:0] v);
    return (v & 16'h3DF4) | 16'h0008;
  endfunction
  function automatic logic [9:0] exp_step(input logic [15:0] v);
    return v[`CTSC_SUP_RES_BIT] ? 10'h2C0 : 10'h160;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait on one flag; running out is a mismatch and ends the run
  task automatic wait_for(input int idx, input logic val);
    int n;
    n = 0;
    while (obs[idx] !== val && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(obs[idx], val);
    if (obs[idx] !== val) wrap_up();
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cfg_wr(input logic [15:0] v);
    @(posedge ref_clk);
    cfgWrEn <= 1'b1;
    cfgWrData <= v;
    @(posedge ref_clk);
    cfgWrEn <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic pulse_reload(input logic rl);
    @(posedge ref_clk);
    if (rl) userReload <= 1'b1;
    else dacWrite <= 1'b1;
    @(posedge ref_clk);
    userReload <= 1'b0;
    dacWrite <= 1'b0;
    idle(2);
  endtask
  // converter speed is drawn per start, so both answer paces are seen
  task automatic start(input logic [15:0] v);
    cfg_wr(v);
    @(posedge ref_clk);
    slow <= 1'($urandom_range(0, 1));
    opOn <= 1'b1;
    wait_for(0, 1'b1);
    @(posedge ref_clk);
    riseElapsed <= 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic stop(input logic fault);
    @(posedge ref_clk);
    opOn <= fault;
    faultOff <= fault;
    riseElapsed <= 1'b0;
    wait_for(0, 1'b0);
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(6));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    check(cfgRdData, 16'h0008);
    check(supStep, 10'h160);
    check(fastServoEn, 1'b1);
    check(enPin.fastPulldown, 1'b1);
    // random words, reserved bits must not show through
    repeat (24) begin
      w = 16'($urandom);
      cfg_wr(w);
      check(cfgRdData, exp_rd(w));
      check(fastServoEn, !w[`CTSC_FAST_OFF_BIT]);
      check(supStep, exp_step(w));
      check(imonBuffered, w[`CTSC_IMON_BIT]);
    end
    // every selector code, unselected pin high first (both low for reserved codes), then both
    for (int s = 0; s < 4; s++) begin
      cfg_wr({2'h0, 2'(s), 12'h018});
      @(posedge ref_clk);
      useSeqPin <= 1'b1;
      opOn <= 1'b1;
      seqA <= (s == 1);
      seqB <= (s == 0);
      idle(8);
      check(chanOn, 1'b0);
      @(posedge ref_clk);
      seqA <= 1'b1;
      seqB <= 1'b1;
      idle(8);
      check(chanOn, (s < 2));
      stop(1'b0);
      check(enPin.fastPulldown, 1'b1);
    end
    @(posedge ref_clk);
    useSeqPin <= 1'b0;
    dacStartup <= 10'($urandom);
    dacRuntime <= 10'($urandom);
    // direct mode from reset uses the startup value until a runtime write
    start(16'h0028);
    wait_for(1, 1'b1);
    check(dacOut, dacStartup);
    pulse_reload(1'b0);
    check(dacOut, dacRuntime);
    stop(1'b0);
    pulse_reload(1'b1);
    start(16'h0028);
    wait_for(1, 1'b1);
    check(dacOut, dacStartup);
    stop(1'b0);
    // disconnected mode never touches the trim pin
    start(16'h0018);
    idle(10);
    check({dacConnected, dacSoftConnecting}, 2'b00);
    stop(1'b0);
    // soft connect then writable
    start(16'h0038);
    wait_for(2, 1'b1);
    check(dacConnected, 1'b1);
    stop(1'b0);
    // single servo, warning ignored without its enable
    start(16'h0008);
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    @(posedge ref_clk);
    overWarn <= 1'b1;
    idle(10);
    check(servoActive, 1'b0);
    check(servoToNominal, 1'b0);
    @(posedge ref_clk);
    overWarn <= 1'b0;
    stop(1'b0);
    start(16'h0048);
    wait_for(3, 1'b1);
    wait_for(3, 1'b0);
    @(posedge ref_clk);
    underWarn <= 1'b1;
    wait_for(4, 1'b1);
    @(posedge ref_clk);
    underWarn <= 1'b0;
    stop(1'b0);
    // continuous servo never leaves, arrivals keep coming meanwhile
    start(16'h0088);
    wait_for(3, 1'b1);
    idle(10);
    check(servoActive, 1'b1);
    idle(10);
    check(servoActive, 1'b1);
    stop(1'b0);
    // soft stop discharges weakly, fault stop still fast
    start(16'h001C);
    check(enPin, 3'b100);
    stop(1'b0);
    check(enPin, 3'b001);
    start(16'h001C);
    stop(1'b1);
    check(enPin, 3'b010);
    @(posedge ref_clk);
    faultOff <= 1'b0;
    opOn <= 1'b0;
    idle(2);
    wrap_up();
  end
endmodule
